// ===== rtl/cib_pkg.sv
package cib_pkg;

    // Register byte addresses on the bus
    localparam logic [7:0] CIB_TX_ID0_OFS  = 8'h00;
    localparam logic [7:0] CIB_TX_ID1_OFS  = 8'h04;
    localparam logic [7:0] CIB_TX_ID2_OFS  = 8'h08;
    localparam logic [7:0] CIB_TX_ID3_OFS  = 8'h0c;
    localparam logic [7:0] CIB_RX_ID0_OFS  = 8'h10;
    localparam logic [7:0] CIB_RX_ID1_OFS  = 8'h14;
    localparam logic [7:0] CIB_RX_ID2_OFS  = 8'h18;
    localparam logic [7:0] CIB_RX_ID3_OFS  = 8'h1c;
    localparam logic [7:0] CIB_CTRL_OFS    = 8'h20;
    localparam logic [7:0] CIB_STATUS_OFS  = 8'h24;

    // Control and status bit positions
    localparam int CIB_CTRL_START_BIT   = 0;
    localparam int CIB_STAT_BUSY_BIT    = 0;
    localparam int CIB_STAT_RXFULL_BIT  = 1;
    localparam int CIB_STAT_TXWINS_BIT  = 2;

    // Field positions inside id_word1 and id_word3
    localparam int CIB_W1_SRR_BIT       = 4;
    localparam int CIB_W1_STD_RTR_BIT   = 4;
    localparam int CIB_W1_IDE_BIT       = 3;
    localparam int CIB_W3_EXT_RTR_BIT   = 0;

    // Identifier area lengths in bus bits
    localparam logic [5:0] CIB_EXT_LEN  = 6'd32;
    localparam logic [5:0] CIB_STD_LEN  = 6'd13;

    localparam logic [7:0] CIB_BYTE_RST = 8'h00;

    typedef logic [3:0][7:0] cib_words_t;

    // Concatenated words are already in bus order, MSB first
    function automatic logic [31:0] cib_frame(input cib_words_t w);
        cib_frame = {w[0], w[1], w[2], w[3]};
    endfunction

    function automatic logic [5:0] cib_len(input cib_words_t w);
        cib_len = w[1][CIB_W1_IDE_BIT] ? CIB_EXT_LEN : CIB_STD_LEN;
    endfunction

    // Left aligned key; standard tail bits zeroed since they are undefined
    function automatic logic [31:0] cib_key(input cib_words_t w);
        if (w[1][CIB_W1_IDE_BIT]) begin
            cib_key = {w[0], w[1], w[2], w[3]};
        end else begin
            cib_key = {w[0], w[1][7:3], 19'h0};
        end
    endfunction

endpackage

// ===== rtl/cib_serializer.sv
`timescale 1ns/1ps
module cib_serializer
    import cib_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        load_i,
    input  wire logic [31:0] frame_i,
    input  wire logic [5:0]  len_i,
    input  wire logic        take_i,
    output logic             bit_o,
    output logic             valid_o
);

    typedef enum logic {CIB_SER_IDLE, CIB_SER_SHIFT} cib_ser_st_t;

    typedef struct packed {
        cib_ser_st_t st;
        logic [31:0] sh;
        logic [5:0]  cnt;
        logic        valid;
    } cib_ser_t;

    cib_ser_t s;
    cib_ser_t next_s;

    always_comb begin
        next_s = s;
        unique case (s.st)
            CIB_SER_IDLE: begin
                if (load_i) begin
                    next_s.st    = CIB_SER_SHIFT;
                    next_s.sh    = frame_i;
                    next_s.cnt   = len_i;
                    next_s.valid = 1'b1;
                end
            end
            CIB_SER_SHIFT: begin
                if (take_i) begin
                    if (s.cnt == 6'd1) begin
                        next_s.st    = CIB_SER_IDLE;
                        next_s.valid = 1'b0;
                    end else begin
                        next_s.sh  = {s.sh[30:0], 1'b0};
                        next_s.cnt = s.cnt - 6'd1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{st: CIB_SER_IDLE, sh: 32'h0, cnt: 6'h0, valid: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign bit_o   = s.sh[31];
    assign valid_o = s.valid;

endmodule // cib_serializer

// ===== rtl/cib_id_buffer.sv
`timescale 1ns/1ps
// Summary of operation
// - Extended id bits 20..18, 17..15, 14..7, 6..0 sit in words one to three.
// - Identifier MSB goes onto the bus first in both formats.
// - Smaller identifier value has the higher priority.
// - Received SRR is stored exactly as sampled.
// - IDE at word1 bit 3 picks standard or extended; it chooses sent format.
// - Received IDE is stored as seen on the bus.
// - Extended RTR is word3 bit 0: zero data, one remote.
// - Received RTR is stored from the frame.
// - Standard id bits 10..3 fill word0, bits 2..0 sit in word1 bits 7:5.
// - Standard RTR at word1 bit 4, IDE at bit 3.
// - Standard unused bits carry no defined content.
// - Extended area is 32 bits, id bits 28..21 fill word0.
// - Standard area is 13 meaningful bits.
module cib_id_buffer
    import cib_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_start_i,
    input  wire logic        rx_bit_valid_i,
    input  wire logic        rx_bit_i,
    input  wire logic        tx_take_i,
    output logic             tx_bit_o,
    output logic             tx_valid_o
);

    typedef struct packed {
        cib_words_t  tx_w;
        cib_words_t  rx_w;
        logic [31:0] rx_sh;
        logic [5:0]  rx_cnt;
        logic        rx_active;
        logic        rx_full;
        logic        start;
        logic        tx_wins;
        logic        ack;
        logic [31:0] dat;
    } cib_state_t;

    cib_state_t s;
    cib_state_t next_s;

    logic       ser_valid;
    logic       req;
    logic       wr;
    logic [5:0] rx_n;
    logic [31:0] rx_shn;

    assign req = wb_cyc_i & wb_stb_i & ~s.ack;
    assign wr  = req & wb_we_i & wb_sel_i[0];

    always_comb begin
        next_s = s;
        rx_n   = s.rx_cnt + 6'd1;
        rx_shn = {s.rx_sh[30:0], rx_bit_i};
        next_s.ack   = req;
        next_s.start = 1'b0;

        // Bus write, one byte lane carries each register
        if (wr) begin
            unique case (wb_adr_i)
                CIB_TX_ID0_OFS: next_s.tx_w[0] = wb_dat_i[7:0];
                CIB_TX_ID1_OFS: next_s.tx_w[1] = wb_dat_i[7:0];
                CIB_TX_ID2_OFS: next_s.tx_w[2] = wb_dat_i[7:0];
                CIB_TX_ID3_OFS: next_s.tx_w[3] = wb_dat_i[7:0];
                CIB_CTRL_OFS: begin
                    // Start while shifting is dropped, the frame in flight wins
                    next_s.start = wb_dat_i[CIB_CTRL_START_BIT] & ~ser_valid & ~s.start;
                end
                CIB_STATUS_OFS: begin
                    if (wb_dat_i[CIB_STAT_RXFULL_BIT]) begin
                        next_s.rx_full = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Bus read, upper bits zero
        next_s.dat = 32'h0;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                CIB_TX_ID0_OFS: next_s.dat[7:0] = s.tx_w[0];
                CIB_TX_ID1_OFS: next_s.dat[7:0] = s.tx_w[1];
                CIB_TX_ID2_OFS: next_s.dat[7:0] = s.tx_w[2];
                CIB_TX_ID3_OFS: next_s.dat[7:0] = s.tx_w[3];
                CIB_RX_ID0_OFS: next_s.dat[7:0] = s.rx_w[0];
                CIB_RX_ID1_OFS: next_s.dat[7:0] = s.rx_w[1];
                CIB_RX_ID2_OFS: next_s.dat[7:0] = s.rx_w[2];
                CIB_RX_ID3_OFS: next_s.dat[7:0] = s.rx_w[3];
                CIB_STATUS_OFS: begin
                    next_s.dat[CIB_STAT_BUSY_BIT]   = ser_valid | s.start;
                    next_s.dat[CIB_STAT_RXFULL_BIT] = s.rx_full;
                    next_s.dat[CIB_STAT_TXWINS_BIT] = s.tx_wins;
                end
                default: ;
            endcase
        end

        // Receive side deserialiser
        if (rx_start_i) begin
            next_s.rx_active = 1'b1;
            next_s.rx_cnt    = 6'h0;
            next_s.rx_sh     = 32'h0;
        end else if (s.rx_active && rx_bit_valid_i) begin
            next_s.rx_sh  = rx_shn;
            next_s.rx_cnt = rx_n;
            // Thirteenth bit is IDE in both layouts
            if (rx_n == CIB_STD_LEN && !rx_shn[0]) begin
                next_s.rx_active = 1'b0;
                next_s.rx_full   = 1'b1;
                next_s.rx_w[0]   = rx_shn[12:5];
                next_s.rx_w[1]   = {rx_shn[4:0], 3'h0};
                // Tail zeroed; software must not rely on it
                next_s.rx_w[2]   = CIB_BYTE_RST;
                next_s.rx_w[3]   = CIB_BYTE_RST;
            end else if (rx_n == CIB_EXT_LEN) begin
                next_s.rx_active = 1'b0;
                next_s.rx_full   = 1'b1;
                // SRR and RTR kept as sampled, never forced
                // First byte on the wire is id_word0, so bytes swap into the packed words
                next_s.rx_w      = {rx_shn[7:0], rx_shn[15:8],
                                    rx_shn[23:16], rx_shn[31:24]};
            end
        end

        // Smaller key wins arbitration
        next_s.tx_wins = cib_key(s.tx_w) < cib_key(s.rx_w);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Frame sent as stored; SRR value is trusted to software
    cib_serializer u_ser (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (s.start),
        .frame_i (cib_frame(s.tx_w)),
        .len_i   (cib_len(s.tx_w)),
        .take_i  (tx_take_i),
        .bit_o   (tx_bit_o),
        .valid_o (ser_valid)
    );

    assign tx_valid_o = ser_valid;
    assign wb_dat_o   = s.dat;
    assign wb_ack_o   = s.ack;

endmodule // cib_id_buffer

// ===== bench/cib_id_buffer_sva.sv
`timescale 1ns/1ps
module cib_id_buffer_chk
    import cib_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tx_take_i,
    input wire logic        tx_bit_o,
    input wire logic        tx_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       req;
    logic [5:0] takes;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Bits consumed in the frame now on the wire
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_valid_o) takes <= 6'h00;
        else if (tx_take_i) takes <= takes + 6'h01;
    end
    property p_ack_now; req |=> wb_ack_o; endproperty
    a_ack_now: assert property (p_ack_now) else $error("no ack");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    property p_ack_cause; wb_ack_o |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_dat_top; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_top: assert property (p_dat_top) else $error("top bits");
    property p_start; req && wb_we_i && wb_sel_i[0] && wb_adr_i == CIB_CTRL_OFS
        && wb_dat_i[CIB_CTRL_START_BIT] && !tx_valid_o |-> ##2 tx_valid_o; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_hold; tx_valid_o && !tx_take_i |=> tx_valid_o && $stable(tx_bit_o); endproperty
    a_hold: assert property (p_hold) else $error("bit moved");
    property p_len; $fell(tx_valid_o) |-> takes == CIB_STD_LEN || takes == CIB_EXT_LEN;
    endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_early; tx_valid_o && tx_take_i && takes < 6'd12 |=> tx_valid_o; endproperty
    a_early: assert property (p_early) else $error("short frame");
endmodule // cib_id_buffer_chk

bind cib_id_buffer cib_id_buffer_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_take_i,
    .tx_bit_o, .tx_valid_o);

// ===== bench/cib_can_node.sv
`timescale 1ns/1ps
module cib_can_node (
    input  wire logic clk_i,
    input  wire logic tx_bit_i,
    output logic      rx_start_o,
    output logic      rx_valid_o,
    output logic      rx_bit_o,
    output logic      take_o
);
    initial {rx_start_o, rx_valid_o, rx_bit_o, take_o} = 4'h0;
    // Idle line shows the inverse, so a stale bit is never taken for good
    task send(input logic [31:0] f, input int n);
        @(posedge clk_i) rx_start_o <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i) rx_start_o <= 1'b0;
            rx_valid_o <= 1'b1;
            rx_bit_o <= f[31-i];
            @(posedge clk_i) rx_valid_o <= 1'b0;
            rx_bit_o <= ~f[31-i];
        end
    endtask
    // Random stalls check that the bit holds until taken
    task recv(input int n, output logic [31:0] got);
        got = 32'h0;
        for (int i = 0; i < n; i++) begin
            repeat ($urandom_range(2) + 1) @(posedge clk_i);
            got = {got[30:0], tx_bit_i};
            take_o <= 1'b1;
            @(posedge clk_i) take_o <= 1'b0;
        end
    endtask
endmodule // cib_can_node

// ===== bench/cib_id_buffer_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end
module cib_id_buffer_tb
    import cib_pkg::*;
;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        rx_start_i, rx_bit_valid_i, rx_bit_i, tx_take_i, tx_bit_o, tx_valid_o;
    logic [7:0]  wb_adr_i, e;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, got, f;
    logic [7:0]  w [4];
    logic [7:0]  q [$];
    int          errors, checked;
    cib_id_buffer dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_start_i, .rx_bit_valid_i,
        .rx_bit_i, .tx_take_i, .tx_bit_o, .tx_valid_o);
    cib_can_node node (.clk_i, .tx_bit_i(tx_bit_o), .rx_start_o(rx_start_i),
        .rx_valid_o(rx_bit_valid_i), .rx_bit_o(rx_bit_i), .take_o(tx_take_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (wb_ack_o && !wb_we_i) begin
            e = q.pop_front();
            `CHK(wb_dat_o, {24'h0, e})
        end
    end
    task close_out();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // For reads d is the value expected back
    task wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, 24'h0, d, s};
        if (!we) q.push_back(d);
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (wb_ack_o) break;
        end
        if (n == 20) errors++;
        if (n == 20) close_out();
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task tx_frame(input int n, input logic [31:0] x);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, CIB_TX_ID0_OFS + 8'(4 * i), w[i], 4'h1);
            wb(1'b0, CIB_TX_ID0_OFS + 8'(4 * i), w[i], 4'h1);
        end
        wb(1'b1, CIB_CTRL_OFS, 8'h01, 4'h1);
        wb(1'b0, CIB_STATUS_OFS, 8'h01, 4'h1);
        node.recv(n, got);
        `CHK(got, x)
        $display("test tx %0d bits done", n);
    endtask
    task rx_frame(input int n, input logic [31:0] r);
        node.send(f, n);
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 4; i++) wb(1'b0, CIB_RX_ID0_OFS + 8'(4 * i), r[31-8*i -: 8], 4'h1);
        $display("test rx %0d bits done", n);
    endtask
    initial begin
        void'($urandom(32'hf7baa2b2));
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, CIB_RX_ID0_OFS, 8'ha5, 4'h1);
        wb(1'b1, CIB_TX_ID0_OFS, 8'h5a, 4'h0);
        wb(1'b1, 8'h30, 8'h3c, 4'h1);
        wb(1'b0, CIB_RX_ID0_OFS, 8'h00, 4'h1);
        wb(1'b0, CIB_TX_ID0_OFS, 8'h00, 4'h1);
        wb(1'b0, 8'h30, 8'h00, 4'h1);
        $display("test refusals done");
        for (int i = 0; i < 4; i++) w[i] = 8'($urandom);
        w[1][4:3] = 2'b11;
        tx_frame(32, {w[0], w[1], w[2], w[3]});
        w[1][3] = 1'b0;
        tx_frame(13, {19'h0, w[0], w[1][7:3]});
        f = $urandom;
        f[19] = 1'b1;
        rx_frame(32, f);
        f[19] = 1'b0;
        rx_frame(13, {f[31:20], 20'h0});
        wb(1'b0, CIB_STATUS_OFS, {5'h0, {w[0], w[1][7:3]} < f[31:19], 2'b10}, 4'h1);
        wb(1'b1, CIB_STATUS_OFS, 8'h02, 4'h1);
        wb(1'b0, CIB_STATUS_OFS, {5'h0, {w[0], w[1][7:3]} < f[31:19], 2'b00}, 4'h1);
        $display("test priority done");
        close_out();
    end
endmodule // cib_id_buffer_tb
